// ===== core/bcr_top.sv
// Control register bank and control logic of the first buck converter
//
// Contract
// - Undervoltage reaction: ignore, shut converter, device reset
// - Undervoltage always sets its status bit and raises the interrupt unless masked
// - Hardware control source selects input one/two/either
// - Hardware control picks run or sleep voltage
// - Hardware control mode field, resets to hysteretic
// - High-current threshold 125mA steps to 1000mA
// - High-current indication only while detect enabled
// - Start-up slot: never or timeslots one-five
// - Slot codes 110/111 follow hardware enables
// - Run mode field, resets to auto mode
// - Seven-bit run voltage, 0.6V-1.8V, 12.5mV
// - Upper run voltage bits loadable from configuration
// - Sleep voltage uses same seven-bit coding
// - Frequency code written only by configuration load
`timescale 1ns/1ps
module bcr_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [16:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Converter monitors
  input wire logic uv_detect,
  input wire logic hc_over,
  // Hardware control and enable pins
  input wire logic hw_ctrl1,
  input wire logic hw_ctrl2,
  input wire logic hw_en1,
  input wire logic hw_en2,
  // Start-up sequencer
  input wire logic slot_strobe,
  input wire logic [2:0] slot_num,
  input wire logic seq_off,
  // Configuration load
  input wire bcr_pkg::bcr_cfg_s cfg,
  // Converter control
  output bcr_pkg::bcr_conv_s conv,
  output logic [2:0] hc_level,
  output logic hc_ind,
  output logic dev_reset_req,
  output logic irq
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] ctrl_ff;
  logic [15:0] run_ff;
  logic [15:0] sleep_ff;
  logic [1:0] freq_ff;
  logic [1:0] stat_ff;
  logic [1:0] snap_ff;
  logic [1:0] mask_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  bcr_pkg::bcr_conv_s conv_ff;
  logic [2:0] hc_level_ff;
  logic hc_ind_ff;
  logic dev_rst_ff;
  logic irq_ff;
  logic uv_d_ff;
  logic uv_shut_ff;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire logic [14:0] idx = avs_address[16:2];
  wire logic any_req = avs_read || avs_write;
  // Every access gets exactly one wait cycle, so the answer time is fixed
  wire logic req = any_req && wait_ff;
  wire logic acc = any_req && !wait_ff;
  wire logic wr = acc && avs_write;
  wire logic hit_ctrl = idx == bcr_pkg::IDX_CTRL;
  wire logic hit_run = idx == bcr_pkg::IDX_RUN;
  wire logic hit_sleep = idx == bcr_pkg::IDX_SLEEP;
  wire logic hit_stat = idx == bcr_pkg::IDX_STAT;
  wire logic hit_mask = idx == bcr_pkg::IDX_MASK;
  wire logic hit_state = idx == bcr_pkg::IDX_STATE;
  wire logic [15:0] be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire logic [15:0] wdat = avs_writedata[15:0];

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] bm,
                                        input logic [15:0] d, input logic [15:0] fm);
    merge = ((old & ~bm) | (d & bm)) & fm;
  endfunction

  // ----------------------------------------
  // Next register values
  // ----------------------------------------
  wire logic [15:0] nxt_ctrl = (wr && hit_ctrl) ? merge(ctrl_ff, be_mask, wdat, bcr_pkg::CTRL_MASK) : ctrl_ff;
  wire logic [15:0] run_w = (wr && hit_run) ? merge(run_ff, be_mask, wdat, bcr_pkg::RUN_MASK) : run_ff;
  // Configuration load overrides a same-cycle write of the upper code bits
  wire logic [15:0] nxt_run = cfg.load ? {run_w[15:7], cfg.vhi, run_w[1:0]} : run_w;
  wire logic [15:0] nxt_sleep = (wr && hit_sleep) ?
                                merge(sleep_ff, be_mask, wdat, bcr_pkg::SLEEP_MASK) : sleep_ff;
  wire logic [1:0] nxt_freq = cfg.load ? cfg.freq : freq_ff;
  wire logic [1:0] nxt_mask = (wr && hit_mask && avs_byteenable[0]) ? wdat[1:0] : mask_ff;

  // ----------------------------------------
  // Field views
  // ----------------------------------------
  wire logic [1:0] err_act = ctrl_ff[bcr_pkg::ERR_LSB +: 2];
  wire logic [1:0] hw_src = ctrl_ff[bcr_pkg::SRC_LSB +: 2];
  wire logic hw_vsel = ctrl_ff[bcr_pkg::VSEL_BIT];
  wire logic [1:0] hw_mode = ctrl_ff[bcr_pkg::HMODE_LSB +: 2];
  wire logic [2:0] thr = ctrl_ff[bcr_pkg::THR_LSB +: 3];
  wire logic hc_on = ctrl_ff[bcr_pkg::HCEN_BIT];
  wire logic [2:0] slot = run_ff[bcr_pkg::SLOT_LSB +: 3];
  wire logic [1:0] run_mode = run_ff[bcr_pkg::RMODE_LSB +: 2];

  // ----------------------------------------
  // Converter control
  // ----------------------------------------
  // Bit 0 of the source picks input one, bit 1 input two, both give either
  wire logic hw_active = (hw_src[0] && hw_ctrl1) || (hw_src[1] && hw_ctrl2);
  wire logic [6:0] sel_code = (hw_active && hw_vsel) ? sleep_ff[6:0] : run_ff[6:0];
  wire logic [1:0] sel_mode = hw_active ? hw_mode : run_mode;
  wire logic hw_off = hw_active && (hw_mode == bcr_pkg::MODE_HW_OFF);
  wire logic en_raw;
  wire logic [6:0] step_w;
  wire logic over_w;

  bcr_enable u_enable (
    .clk(clk),
    .rst(rst),
    .slot(slot),
    .uv_shut(uv_shut_ff),
    .slot_strobe(slot_strobe),
    .slot_num(slot_num),
    .seq_off(seq_off),
    .hw_en1(hw_en1),
    .hw_en2(hw_en2),
    .en(en_raw)
  );

  bcr_vmap u_vmap (
    .code(sel_code),
    .freq(freq_ff),
    .step(step_w),
    .over_limit(over_w)
  );

  wire bcr_pkg::bcr_conv_s nxt_conv = '{en: en_raw && !hw_off, mode: sel_mode, step: step_w};

  // ----------------------------------------
  // Events and interrupt
  // ----------------------------------------
  wire logic uv_rise = uv_detect && !uv_d_ff;
  wire logic hc_now = hc_on && hc_over;
  wire logic hc_rise = hc_now && !hc_ind_ff;
  wire logic [1:0] ev = {hc_rise, uv_rise};
  // Only the bits actually returned are cleared, so a late event survives
  wire logic [1:0] clr = (acc && avs_read && hit_stat) ? snap_ff : 2'h0;
  wire logic [1:0] nxt_stat = (stat_ff & ~clr) | ev;
  wire logic shut_set = uv_rise && (err_act == bcr_pkg::ERR_SHUT);
  wire logic nxt_shut = shut_set || (uv_shut_ff && !(wr && hit_ctrl));

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire bcr_pkg::bcr_state_s st = '{hc_ind: hc_ind_ff, over_limit: over_w, hw_active: hw_active,
                                   uv_shut: uv_shut_ff, freq: freq_ff, step: conv_ff.step,
                                   mode: conv_ff.mode, en: conv_ff.en};
  wire logic [15:0] rd_word = hit_ctrl ? ctrl_ff :
                              hit_run ? run_ff :
                              hit_sleep ? sleep_ff :
                              hit_stat ? {14'h0000, stat_ff} :
                              hit_mask ? {14'h0000, mask_ff} :
                              hit_state ? st : 16'h0000;

  // ----------------------------------------
  // Register update
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff <= bcr_pkg::CTRL_RST;
      run_ff <= bcr_pkg::RUN_RST;
      sleep_ff <= bcr_pkg::SLEEP_RST;
      freq_ff <= bcr_pkg::FREQ_RST;
      mask_ff <= 2'h0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      run_ff <= nxt_run;
      sleep_ff <= nxt_sleep;
      freq_ff <= nxt_freq;
      mask_ff <= nxt_mask;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
      snap_ff <= 2'h0;
      stat_ff <= 2'h0;
      irq_ff <= 1'b0;
    end else begin
      wait_ff <= !req;
      rdata_ff <= (req && avs_read) ? {16'h0000, rd_word} : rdata_ff;
      snap_ff <= req ? stat_ff : snap_ff;
      stat_ff <= nxt_stat;
      irq_ff <= |(nxt_stat & ~nxt_mask);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      conv_ff <= '0;
      hc_level_ff <= 3'h0;
      hc_ind_ff <= 1'b0;
      dev_rst_ff <= 1'b0;
      uv_d_ff <= 1'b0;
      uv_shut_ff <= 1'b0;
    end else begin
      conv_ff <= nxt_conv;
      hc_level_ff <= thr;
      hc_ind_ff <= hc_now;
      dev_rst_ff <= uv_rise && (err_act == bcr_pkg::ERR_RESET);
      uv_d_ff <= uv_detect;
      uv_shut_ff <= nxt_shut;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign conv = conv_ff;
  assign hc_level = hc_level_ff;
  assign hc_ind = hc_ind_ff;
  assign dev_reset_req = dev_rst_ff;
  assign irq = irq_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_uv_status_set: assert property (uv_rise |=> stat_ff[bcr_pkg::IRQ_UV])
    else $error("undervoltage did not set status");
  a_uv_irq_out: assert property (uv_rise && !nxt_mask[bcr_pkg::IRQ_UV] |=> irq_ff)
    else $error("undervoltage did not raise interrupt");
  a_uv_shut_latch: assert property (shut_set |=> uv_shut_ff ##1 !conv_ff.en)
    else $error("shut reaction did not stop converter");
  a_uv_dev_reset: assert property (uv_rise && err_act == bcr_pkg::ERR_RESET |=> dev_rst_ff ##1 !dev_rst_ff)
    else $error("device reset pulse wrong");
  a_uv_ignore_quiet: assert property (uv_rise && err_act == bcr_pkg::ERR_IGNORE && !uv_shut_ff |=>
    !dev_rst_ff && !uv_shut_ff)
    else $error("ignore reaction acted");
  // Sampled reset masks the release edge, where conv still holds its reset value
  a_hw_mode_pick: assert property (!rst && hw_active |=> conv_ff.mode == $past(hw_mode))
    else $error("hardware mode not applied");
  a_run_mode_pick: assert property (!rst && !hw_active |=> conv_ff.mode == $past(run_mode))
    else $error("run mode not applied");
  a_sleep_vsel: assert property (hw_active && hw_vsel && sleep_ff[6:0] > bcr_pkg::VMIN_CODE &&
    sleep_ff[6:0] < bcr_pkg::VMAX_CODE |=> conv_ff.step == $past(sleep_ff[6:0]) - bcr_pkg::VMIN_CODE)
    else $error("sleep voltage not applied");
  a_step_floor: assert property (sel_code <= bcr_pkg::VMIN_CODE |=> conv_ff.step == 7'h00)
    else $error("low code not clamped to minimum");
  a_hc_gate_off: assert property (!hc_on |=> !hc_ind_ff)
    else $error("high-current indication while disabled");
  a_hc_level_follow: assert property (##1 hc_level_ff == $past(thr))
    else $error("threshold output stale");
  a_cfg_load_vhi: assert property (cfg.load |=> run_ff[6:2] == $past(cfg.vhi))
    else $error("configuration load missed");
  a_freq_read_only: assert property (!cfg.load |=> freq_ff == $past(freq_ff))
    else $error("frequency changed without load");
  a_ctrl_reserved_zero: assert property (acc && avs_read && hit_ctrl |->
    (rdata_ff[15:0] & ~bcr_pkg::CTRL_MASK) == 16'h0000)
    else $error("reserved bits read nonzero");
  a_bus_one_wait: assert property (req |=> !wait_ff ##1 wait_ff)
    else $error("wait timing wrong");

  c_uv_shut: cover property (shut_set ##2 !conv_ff.en);
  c_hw_sleep: cover property (hw_active && hw_vsel);
  c_stat_read: cover property (acc && avs_read && hit_stat && snap_ff != 2'h0);
  c_hc_event: cover property (hc_rise);
endmodule

// ===== core/bcr_pkg.sv
// Shared constants and carriers for the first buck converter control bank
package bcr_pkg;
  // ----------------------------------------
  // Register indices (byte address = 4 x index)
  // ----------------------------------------
  localparam logic [14:0] IDX_CTRL = 15'h4057;
  localparam logic [14:0] IDX_RUN = 15'h4058;
  localparam logic [14:0] IDX_SLEEP = 15'h4060;
  localparam logic [14:0] IDX_STAT = 15'h4061;
  localparam logic [14:0] IDX_MASK = 15'h4062;
  localparam logic [14:0] IDX_STATE = 15'h4063;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int ERR_LSB = 14;
  localparam int SRC_LSB = 11;
  localparam int VSEL_BIT = 10;
  localparam int HMODE_LSB = 8;
  localparam int THR_LSB = 4;
  localparam int HCEN_BIT = 0;
  localparam int SLOT_LSB = 13;
  localparam int RMODE_LSB = 8;
  localparam int VHI_LSB = 2;
  localparam int IRQ_UV = 0;
  localparam int IRQ_HC = 1;
  // ----------------------------------------
  // Writable masks and reset values
  // ----------------------------------------
  localparam logic [15:0] CTRL_MASK = 16'hDF71;
  localparam logic [15:0] CTRL_RST = 16'h0300;
  localparam logic [15:0] RUN_MASK = 16'hE37F;
  localparam logic [15:0] RUN_RST = 16'h0100;
  localparam logic [15:0] SLEEP_MASK = 16'h007F;
  localparam logic [15:0] SLEEP_RST = 16'h0000;
  localparam logic [1:0] FREQ_RST = 2'h0;
  // ----------------------------------------
  // Codes
  // ----------------------------------------
  localparam logic [1:0] ERR_IGNORE = 2'h0;
  localparam logic [1:0] ERR_SHUT = 2'h1;
  localparam logic [1:0] ERR_RESET = 2'h2;
  localparam logic [1:0] MODE_HW_OFF = 2'h1;
  localparam logic [2:0] SLOT_FIRST = 3'h1;
  localparam logic [2:0] SLOT_LAST = 3'h5;
  localparam logic [2:0] SLOT_HWEN1 = 3'h6;
  localparam logic [2:0] SLOT_HWEN2 = 3'h7;
  localparam logic [6:0] VMIN_CODE = 7'h08;
  localparam logic [6:0] VMAX_CODE = 7'h68;
  localparam logic [6:0] VSTEP_MAX = 7'h60;
  localparam logic [6:0] V4M_MAX = 7'h48;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic load;
    logic [4:0] vhi;
    logic [1:0] freq;
  } bcr_cfg_s;
  typedef struct packed {
    logic en;
    logic [1:0] mode;
    logic [6:0] step;
  } bcr_conv_s;
  typedef struct packed {
    logic hc_ind;
    logic over_limit;
    logic hw_active;
    logic uv_shut;
    logic [1:0] freq;
    logic [6:0] step;
    logic [1:0] mode;
    logic en;
  } bcr_state_s;
endpackage

// ===== core/bcr_vmap.sv
// Voltage code to linear step index, with fast-switching limit check
`timescale 1ns/1ps
module bcr_vmap (
  // Code in
  input wire logic [6:0] code,
  input wire logic [1:0] freq,
  // Step out
  output logic [6:0] step,
  output logic over_limit
);
  wire logic low = code <= bcr_pkg::VMIN_CODE;
  wire logic high = code >= bcr_pkg::VMAX_CODE;
  wire logic [6:0] lin = code - bcr_pkg::VMIN_CODE;
  // Step 0 is the minimum, step 60h the maximum output
  assign step = low ? 7'h00 : (high ? bcr_pkg::VSTEP_MAX : lin);
  // Codes 10 and 11 both mean fast switching; software must keep below the limit
  assign over_limit = freq[1] && (code > bcr_pkg::V4M_MAX);
endmodule

// ===== core/bcr_enable.sv
// Start-up slot and hardware enable selection for the converter
`timescale 1ns/1ps
module bcr_enable (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration
  input wire logic [2:0] slot,
  input wire logic uv_shut,
  // Sequencer and pins
  input wire logic slot_strobe,
  input wire logic [2:0] slot_num,
  input wire logic seq_off,
  input wire logic hw_en1,
  input wire logic hw_en2,
  // Result
  output logic en
);
  logic on_ff;
  wire logic seq_slot = (slot >= bcr_pkg::SLOT_FIRST) && (slot <= bcr_pkg::SLOT_LAST);
  wire logic hit = slot_strobe && seq_slot && (slot_num == slot);
  wire logic nxt_on = (on_ff && !seq_off && seq_slot) || hit;
  wire logic pin_en = (slot == bcr_pkg::SLOT_HWEN2) ? hw_en2 : hw_en1;

  always_ff @(posedge clk) begin
    on_ff <= rst ? 1'b0 : nxt_on;
  end

  // Slots 110 and 111 bypass the sequencer entirely
  assign en = !uv_shut && (slot >= bcr_pkg::SLOT_HWEN1 ? pin_en : on_ff);

  a_slot_timed: assert property (@(posedge clk) disable iff (rst)
    hit |=> on_ff);
  a_slot_never: assert property (@(posedge clk) disable iff (rst)
    slot == 3'h0 |=> !on_ff);
endmodule

// ===== verif/tb.sv
// Self-checking bench for the first buck converter control bank
`timescale 1ns/1ps
module tb;
  // ----------------------------------------
  // Stimulus and design hookup
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [16:0] avs_address = 17'h00000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'h3;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic uv_detect = 1'b0;
  logic hc_over = 1'b0;
  logic hw_ctrl1 = 1'b0;
  logic hw_ctrl2 = 1'b0;
  logic hw_en1 = 1'b0;
  logic hw_en2 = 1'b0;
  logic slot_strobe = 1'b0;
  logic [2:0] slot_num = 3'h0;
  logic seq_off = 1'b0;
  bcr_pkg::bcr_cfg_s cfg = '0;
  bcr_pkg::bcr_conv_s conv;
  logic [2:0] hc_level;
  logic hc_ind;
  logic dev_reset_req;
  logic irq;
  int miscompares = 0;
  int cmp_count = 0;
  int pulses;
  logic [15:0] rd;
  logic [6:0] codes [7] = '{7'h00, 7'h08, 7'h09, 7'h48, 7'h67, 7'h68, 7'h7F};

  always #12.5 clk = ~clk;

  bcr_top bcr_top_i (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .uv_detect(uv_detect),
    .hc_over(hc_over), .hw_ctrl1(hw_ctrl1), .hw_ctrl2(hw_ctrl2), .hw_en1(hw_en1), .hw_en2(hw_en2),
    .slot_strobe(slot_strobe), .slot_num(slot_num), .seq_off(seq_off), .cfg(cfg), .conv(conv),
    .hc_level(hc_level), .hc_ind(hc_ind), .dev_reset_req(dev_reset_req), .irq(irq));

  // ----------------------------------------
  // Report, compare and bus tasks
  // ----------------------------------------
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Called right after a rising edge; request held until waitrequest seen low
  task automatic bus(input logic wr, input logic [14:0] idx, input logic [15:0] wd);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {16'h0000, wd};
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      close_out();
    end else begin
      rd = avs_readdata[15:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic rchk(input logic [14:0] idx, input logic [15:0] exp);
    bus(1'b0, idx, 16'h0000);
    check(rd, exp);
  endtask

  task automatic wctl(input logic [15:0] d);
    bus(1'b1, bcr_pkg::IDX_CTRL, d);
    tick(2);
  endtask

  task automatic wrun(input logic [15:0] d);
    bus(1'b1, bcr_pkg::IDX_RUN, d);
    tick(2);
  endtask

  task automatic conv_chk(input logic en, input logic [1:0] md, input logic [6:0] st);
    check({6'h00, conv.en, conv.mode, conv.step}, {6'h00, en, md, st});
  endtask

  // Sequencer pulse: timeslot strobe or power-down
  task automatic seq_pulse(input logic [2:0] n, input logic off);
    slot_num <= n;
    slot_strobe <= ~off;
    seq_off <= off;
    @(posedge clk);
    slot_strobe <= 1'b0;
    seq_off <= 1'b0;
    tick(3);
  endtask

  // Rising undervoltage; counts reset request cycles seen meanwhile
  task automatic uv_event();
    uv_detect <= 1'b1;
    pulses = 0;
    repeat (4) begin
      @(posedge clk);
      pulses += int'(dev_reset_req);
    end
    uv_detect <= 1'b0;
    tick(2);
  endtask

  // Linear step expected from a seven-bit voltage code, clamped at both ends
  function automatic logic [6:0] vstep(input logic [6:0] c);
    if (c <= 7'h08) return 7'h00;
    if (c >= 7'h68) return 7'h60;
    return c - 7'h08;
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    tick(2);
    rchk(bcr_pkg::IDX_CTRL, 16'h0300);
    rchk(bcr_pkg::IDX_RUN, 16'h0100);
    rchk(bcr_pkg::IDX_SLEEP, 16'h0000);
    rchk(15'h0100, 16'h0000);
    wctl(16'hFFFF);
    rchk(bcr_pkg::IDX_CTRL, 16'hDF71);
    wrun(16'hFFFF);
    rchk(bcr_pkg::IDX_RUN, 16'hE37F);
    bus(1'b1, 15'h0100, 16'hFFFF);
    rchk(15'h0100, 16'h0000);
    wrun(16'h0100);
    for (int t = 0; t < 8; t++) begin
      wctl(16'(t << 4));
      check({13'h0000, hc_level}, 16'(t));
    end
    hc_over <= 1'b1;
    wctl(16'h0000);
    check({15'h0000, hc_ind}, 16'h0000);
    rchk(bcr_pkg::IDX_STAT, 16'h0000);
    wctl(16'h0001);
    check({14'h0000, hc_ind, irq}, 16'h0003);
    rchk(bcr_pkg::IDX_STAT, 16'h0002);
    hc_over <= 1'b0;
    wctl(16'h0000);
    check({15'h0000, irq}, 16'h0000);
    foreach (codes[i]) begin
      wrun(16'h0000 | (16'(i % 4) << 8) | 16'(codes[i]));
      conv_chk(1'b0, 2'(i % 4), vstep(codes[i]));
    end
    wrun(16'h0101);
    cfg <= '{load: 1'b1, vhi: 5'h12, freq: 2'h2};
    @(posedge clk);
    cfg <= '{load: 1'b0, vhi: 5'h00, freq: 2'h0};
    tick(2);
    rchk(bcr_pkg::IDX_RUN, 16'h0149);
    bus(1'b0, bcr_pkg::IDX_STATE, 16'h0000);
    check(rd & 16'h4C00, 16'h4800);
    wrun(16'h0148);
    bus(1'b0, bcr_pkg::IDX_STATE, 16'h0000);
    check(rd & 16'h4C00, 16'h0800);
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 4; p++) begin
        wctl(16'(s << 11));
        hw_ctrl1 <= p[0];
        hw_ctrl2 <= p[1];
        tick(2);
        bus(1'b0, bcr_pkg::IDX_STATE, 16'h0000);
        check(rd & 16'h2000, ((s[0] & p[0]) | (s[1] & p[1])) ? 16'h2000 : 16'h0000);
      end
    end
    bus(1'b1, bcr_pkg::IDX_SLEEP, 16'hFFB0);
    rchk(bcr_pkg::IDX_SLEEP, 16'h0030);
    wrun(16'h0120);
    hw_ctrl1 <= 1'b1;
    wctl(16'h0B00);
    conv_chk(1'b0, 2'h3, 7'h18);
    wctl(16'h0E00);
    conv_chk(1'b0, 2'h2, 7'h28);
    hw_ctrl1 <= 1'b0;
    tick(3);
    conv_chk(1'b0, 2'h1, 7'h18);
    hw_en1 <= 1'b1;
    wrun(16'hC120);
    conv_chk(1'b1, 2'h1, 7'h18);
    hw_ctrl1 <= 1'b1;
    wctl(16'h0900);
    conv_chk(1'b0, 2'h1, 7'h18);
    hw_ctrl1 <= 1'b0;
    hw_en1 <= 1'b0;
    wrun(16'hE120);
    conv_chk(1'b0, 2'h1, 7'h18);
    hw_en2 <= 1'b1;
    tick(3);
    conv_chk(1'b1, 2'h1, 7'h18);
    hw_en2 <= 1'b0;
    wrun(16'h6120);
    seq_pulse(3'h2, 1'b0);
    conv_chk(1'b0, 2'h1, 7'h18);
    seq_pulse(3'h3, 1'b0);
    conv_chk(1'b1, 2'h1, 7'h18);
    seq_pulse(3'h0, 1'b1);
    conv_chk(1'b0, 2'h1, 7'h18);
    hw_en1 <= 1'b1;
    wrun(16'hC120);
    for (int r = 0; r < 4; r++) begin
      wctl(16'(r << 14));
      uv_event();
      check(16'(pulses), (r == 2) ? 16'h0001 : 16'h0000);
      check({14'h0000, conv.en, irq}, {14'h0000, r != 1, 1'b1});
      rchk(bcr_pkg::IDX_STAT, 16'h0001);
      tick(2);
      check({15'h0000, irq}, 16'h0000);
    end
    bus(1'b1, bcr_pkg::IDX_MASK, 16'h0001);
    rchk(bcr_pkg::IDX_MASK, 16'h0001);
    uv_event();
    check({15'h0000, irq}, 16'h0000);
    rchk(bcr_pkg::IDX_STAT, 16'h0001);
    // Mid-run reset must bring back the mask and control registers and the converter word
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(2);
    rchk(bcr_pkg::IDX_MASK, 16'h0000);
    rchk(bcr_pkg::IDX_CTRL, 16'h0300);
    conv_chk(1'b0, 2'h1, 7'h00);
    close_out();
  end
endmodule
